//--- verilog/timer_consts.svh
`ifndef TIMER_CONSTS_SVH
`define TIMER_CONSTS_SVH
`define ADDR_FLAGS 5'h0c
`define ADDR_COUNT_LO 5'h0e
`define ADDR_COUNT_HI 5'h0f
`define ADDR_CONTROL 5'h10
`define ADDR_COMPARE_LO 5'h15
`define ADDR_COMPARE_HI 5'h16
`define ADDR_COMPARE_CTL 5'h17
`define BIT_ON 0
`define BIT_CLKSEL 1
`define BIT_SYNCBYP 2
`define BIT_OSCEN 3
`define BIT_PS_LO 4
`define BIT_PS_HI 5
`define BIT_OVF 0
`define CONTROL_RESET 8'h00
`define CONTROL_MASK 8'h3f
`define FLAGS_MASK 8'h01
`define COMPARE_CTL_MASK 8'h0f
`define TRIGGER_MODE 4'hb
`define COUNT_POWERUP 16'h0000
`endif

//--- verilog/timer_pkg.sv
package timer_pkg;
   typedef logic [7:0] byte_t;
   typedef logic [15:0] count_t;
endpackage : timer_pkg

//--- verilog/sixteen_bit_timer_counter.sv
// Overview of operation
// - Bypass bit only blocks the trigger clear; external edges still pass the synchronisers and ON gating
// - Unsynchronised mode keeps counting, overflow sets flag
// - Unsynchronised mode gives no compare time base
// - Count reads are always coherent values
// - Oscillator enable drives crystal amplifier output
// - Compare trigger mode 1011 clears count
// - Trigger clear never sets overflow flag
// - Trigger clear only in synchronised modes
// - Count byte write beats simultaneous trigger clear for that byte; the other byte still clears
// - Compare pair acts as period register
// - Count bytes untouched by any reset
// - Control resets to zero on power reset
// - Count held as two byte registers
// - Count byte write clears the prescaler
`timescale 1ns/1ps
`include "timer_consts.svh"
module sixteen_bit_timer_counter (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic powerOnReset,
   input wire logic [4:0] addr,
   input wire timer_pkg::byte_t writeData,
   input wire logic writeStrobe,
   input wire logic readStrobe,
   output timer_pkg::byte_t readData,
   input wire logic externalCountInput,
   input wire logic crystalInputPin,
   output logic crystalOutputPin,
   input wire logic instrClockTick,
   output logic counterOverflowFlag,
   output logic compareMatch
);
   import timer_pkg::*;

   localparam int NUM_PINS = 2;
   localparam int PIN_EXT = 0;
   localparam int PIN_XTAL = 1;
   localparam int NUM_BYTES = 2;

   byte_t counterControl;
   byte_t next_control;
   byte_t countByte [NUM_BYTES];
   byte_t compareByte [NUM_BYTES];
   logic [3:0] compareModeField;
   logic [2:0] prescaleCount;
   logic [2:0] next_prescale;
   logic [2:0] prescaleLimit;
   logic [NUM_PINS-1:0] pinRaw;
   logic [NUM_PINS-1:0] pinSync;
   logic [NUM_PINS-1:0] pinRise;
   logic counterOn;
   logic clockSelect;
   logic syncBypass;
   logic oscEnable;
   logic asyncMode;
   logic sourceEdge;
   logic prescaleWrap;
   logic prescaleTick;
   logic controlWrite;
   logic flagsWrite;
   logic compareCtlWrite;
   logic [NUM_BYTES-1:0] byteWrite;
   logic [NUM_BYTES-1:0] compareWrite;
   logic countWrite;
   logic modeIsTrigger;
   logic countAtCompare;
   logic trigger;
   logic rollover;
   logic next_flag;
   count_t wideCounter;
   count_t comparePair;
   count_t next_count;
   byte_t next_readData;

   function automatic logic hit(input logic [4:0] a, input logic [4:0] target);
      hit = a == target;
   endfunction : hit

   // Source events per count tick minus one, for each prescale code
   function automatic logic [2:0] limit_of(input logic [1:0] code);
      unique case (code)
         2'b00: limit_of = 3'h0;
         2'b01: limit_of = 3'h1;
         2'b10: limit_of = 3'h3;
         2'b11: limit_of = 3'h7;
      endcase
   endfunction : limit_of

   assign controlWrite = writeStrobe && hit(addr, `ADDR_CONTROL);
   assign flagsWrite = writeStrobe && hit(addr, `ADDR_FLAGS);
   assign compareCtlWrite = writeStrobe && hit(addr, `ADDR_COMPARE_CTL);
   assign byteWrite[0] = writeStrobe && hit(addr, `ADDR_COUNT_LO);
   assign byteWrite[1] = writeStrobe && hit(addr, `ADDR_COUNT_HI);
   assign compareWrite[0] = writeStrobe && hit(addr, `ADDR_COMPARE_LO);
   assign compareWrite[1] = writeStrobe && hit(addr, `ADDR_COMPARE_HI);
   assign countWrite = |byteWrite;

   assign counterOn = counterControl[`BIT_ON];
   assign clockSelect = counterControl[`BIT_CLKSEL];
   assign syncBypass = counterControl[`BIT_SYNCBYP];
   assign oscEnable = counterControl[`BIT_OSCEN];
   assign asyncMode = clockSelect && syncBypass;

   assign pinRaw[PIN_EXT] = externalCountInput;
   assign pinRaw[PIN_XTAL] = crystalInputPin;

   // Each pin passes two flip-flops before its edge detector reads it
   for (genvar p = 0; p < NUM_PINS; p++) begin : g_pin
      logic meta;
      logic sync;
      logic last;

      always_ff @(posedge sys_clk) begin
         meta <= pinRaw[p];
         sync <= meta;
         last <= sync;
      end

      assign pinSync[p] = sync;
      assign pinRise[p] = sync && !last;
   end

   // Instruction clock tick when clock select is clear; else oscillator path when enabled, otherwise the external input pin
   always_comb begin
      if (!clockSelect) begin
         sourceEdge = instrClockTick;
      end else if (oscEnable) begin
         sourceEdge = pinRise[PIN_XTAL];
      end else begin
         sourceEdge = pinRise[PIN_EXT];
      end
   end

   assign prescaleLimit = limit_of(counterControl[`BIT_PS_HI:`BIT_PS_LO]);
   assign prescaleWrap = prescaleCount >= prescaleLimit;
   assign prescaleTick = counterOn && sourceEdge && prescaleWrap;

   always_comb begin
      next_prescale = prescaleCount;
      if (countWrite) begin
         next_prescale = 3'h0;
      end else if (counterOn && sourceEdge) begin
         if (prescaleWrap) begin
            next_prescale = 3'h0;
         end else begin
            next_prescale = prescaleCount + 3'h1;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         prescaleCount <= 3'h0;
      end else begin
         prescaleCount <= next_prescale;
      end
   end

   assign wideCounter = {countByte[1], countByte[0]};
   assign comparePair = {compareByte[1], compareByte[0]};

   // Compare match drives the clear only in synchronised modes
   assign modeIsTrigger = compareModeField == `TRIGGER_MODE;
   assign countAtCompare = wideCounter == comparePair;
   assign trigger = modeIsTrigger && countAtCompare && !asyncMode;

   // A trigger clear or a count write is never an overflow
   assign rollover = prescaleTick && (wideCounter == 16'hffff)
      && !trigger && !countWrite;

   always_comb begin
      next_count = wideCounter;
      if (prescaleTick) begin
         next_count = wideCounter + 16'h0001;
      end
      if (trigger) begin
         next_count = `COUNT_POWERUP;
      end
   end

   // Count bytes have no reset term; a write overrides the trigger
   for (genvar b = 0; b < NUM_BYTES; b++) begin : g_count
      always_ff @(posedge sys_clk) begin
         if (byteWrite[b]) begin
            countByte[b] <= writeData;
         end else begin
            countByte[b] <= next_count[8*b +: 8];
         end
      end
   end

   for (genvar c = 0; c < NUM_BYTES; c++) begin : g_compare
      always_ff @(posedge sys_clk) begin
         if (rst) begin
            compareByte[c] <= 8'h00;
         end else if (compareWrite[c]) begin
            compareByte[c] <= writeData;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         compareModeField <= 4'h0;
      end else if (compareCtlWrite) begin
         compareModeField <= writeData[3:0];
      end
   end

   always_comb begin
      next_control = counterControl;
      if (controlWrite) begin
         next_control = writeData & `CONTROL_MASK;
      end
   end

   // Only a power reset clears control; the general reset leaves it
   always_ff @(posedge sys_clk) begin
      if (powerOnReset) begin
         counterControl <= `CONTROL_RESET;
      end else begin
         counterControl <= next_control;
      end
   end

   // Overflow set wins over a software clear in the same cycle
   always_comb begin
      next_flag = counterOverflowFlag;
      if (rollover) begin
         next_flag = 1'b1;
      end else if (flagsWrite) begin
         next_flag = writeData[`BIT_OVF];
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         counterOverflowFlag <= 1'b0;
      end else begin
         counterOverflowFlag <= next_flag;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         compareMatch <= 1'b0;
      end else begin
         compareMatch <= trigger;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         crystalOutputPin <= 1'b0;
      end else begin
         crystalOutputPin <= oscEnable && !pinSync[PIN_XTAL];
      end
   end

   // Count bytes live in this domain, so a read is always coherent
   always_comb begin
      next_readData = 8'h00;
      if (readStrobe) begin
         unique case (addr)
            `ADDR_FLAGS: next_readData = {7'h00, counterOverflowFlag};
            `ADDR_COUNT_LO: next_readData = countByte[0];
            `ADDR_COUNT_HI: next_readData = countByte[1];
            `ADDR_CONTROL: next_readData = counterControl;
            `ADDR_COMPARE_LO: next_readData = compareByte[0];
            `ADDR_COMPARE_HI: next_readData = compareByte[1];
            `ADDR_COMPARE_CTL: next_readData = {4'h0, compareModeField};
            default: next_readData = 8'h00;
         endcase
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         readData <= 8'h00;
      end else begin
         readData <= next_readData;
      end
   end

endmodule : sixteen_bit_timer_counter

//--- verification/timer_checker.sv
`timescale 1ns/1ps
`include "timer_consts.svh"
module timer_checker (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic powerOnReset,
   input wire logic [4:0] addr,
   input wire logic writeStrobe,
   input wire logic readStrobe,
   input wire timer_pkg::byte_t readData,
   input wire logic crystalOutputPin,
   input wire logic counterOverflowFlag,
   input wire logic compareMatch
);
   import timer_pkg::*;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   chk_read_idle: assert property (!readStrobe |=> readData == 8'h00)
      else $error("read data outside read");
   chk_control_width: assert property (readStrobe && addr == `ADDR_CONTROL |=>
      readData[7:6] == 2'h0) else $error("control top bits set");
   chk_flags_width: assert property (readStrobe && addr == `ADDR_FLAGS |=>
      readData[7:1] == 7'h00) else $error("flags top bits set");
   chk_unmapped_zero: assert property (readStrobe && addr == 5'h01 |=>
      readData == 8'h00) else $error("unmapped read not zero");
   chk_flag_sticky: assert property (counterOverflowFlag &&
      !(writeStrobe && addr == `ADDR_FLAGS) |=> counterOverflowFlag) else $error("flag lost");
   chk_match_noflag: assert property ($rose(compareMatch) |->
      !$rose(counterOverflowFlag)) else $error("trigger set flag");
   chk_power_osc_off: assert property (powerOnReset |-> ##2 !crystalOutputPin)
      else $error("oscillator on after power reset");
   chk_reset_outputs: assert property (disable iff (1'b0) rst |=> readData == 8'h00 &&
      !compareMatch && !counterOverflowFlag) else $error("outputs not cleared by reset");
endmodule : timer_checker
bind sixteen_bit_timer_counter timer_checker i_timer_checker(.sys_clk(sys_clk), .rst(rst),
   .powerOnReset(powerOnReset), .addr(addr), .writeStrobe(writeStrobe),
   .readStrobe(readStrobe), .readData(readData), .crystalOutputPin(crystalOutputPin),
   .counterOverflowFlag(counterOverflowFlag), .compareMatch(compareMatch));

//--- verification/count_source.sv
`timescale 1ns/1ps
module count_source (
   input wire logic run,
   output logic edgeOut
);
   initial edgeOut = 1'b0;
   // Pulses at a 400 ns period while run is high, idle low otherwise
   always begin
      wait (run);
      #7 edgeOut = 1'b1;
      #200 edgeOut = 1'b0;
      #193;
   end
endmodule : count_source

//--- verification/tb_top.sv
`timescale 1ns/1ps
`include "timer_consts.svh"
module tb_top;
   import timer_pkg::*;
   logic sys_clk = 0, rst = 1, powerOnReset = 1, writeStrobe = 0, readStrobe = 0;
   logic instrClockTick = 0, run = 0, edgeOut, crystalOutputPin, counterOverflowFlag;
   logic compareMatch;
   logic [4:0] addr = 5'h00;
   byte_t writeData = 8'h00, readData;
   int num_errors = 0, checks = 0, matchCount = 0;
   always #25 sys_clk = ~sys_clk;
   count_source i_count_source(.run(run), .edgeOut(edgeOut));
   sixteen_bit_timer_counter i_sixteen_bit_timer_counter(.sys_clk(sys_clk), .rst(rst),
      .powerOnReset(powerOnReset), .addr(addr), .writeData(writeData),
      .writeStrobe(writeStrobe), .readStrobe(readStrobe), .readData(readData),
      .externalCountInput(edgeOut), .crystalInputPin(edgeOut),
      .crystalOutputPin(crystalOutputPin), .instrClockTick(instrClockTick),
      .counterOverflowFlag(counterOverflowFlag), .compareMatch(compareMatch));
   // Counts every cycle in which the design reports a compare clear
   always @(posedge sys_clk) begin
      if (compareMatch === 1'b1) matchCount <= matchCount + 1;
   end
   task automatic check_value(input logic [15:0] got, input logic [15:0] e);
      checks++;
      if (got !== e) begin
         num_errors++;
         $display("Error at %0t: got %h expected %h", $time, got, e);
      end
   endtask : check_value
   // Two writes on consecutive cycles with no gap between the strobes
   task automatic wr2(input logic [4:0] a0, input byte_t d0, input logic [4:0] a1,
      input byte_t d1);
      @(posedge sys_clk);
      addr <= a0;
      writeData <= d0;
      writeStrobe <= 1'b1;
      @(posedge sys_clk);
      addr <= a1;
      writeData <= d1;
      @(posedge sys_clk);
      writeStrobe <= 1'b0;
   endtask : wr2
   task automatic wr(input logic [4:0] a, input byte_t d);
      @(posedge sys_clk);
      addr <= a;
      writeData <= d;
      writeStrobe <= 1'b1;
      @(posedge sys_clk);
      writeStrobe <= 1'b0;
   endtask : wr
   task automatic rd(input logic [4:0] a, input byte_t e);
      @(posedge sys_clk);
      addr <= a;
      readStrobe <= 1'b1;
      @(posedge sys_clk);
      readStrobe <= 1'b0;
      #1 checks++;
      if (readData !== e) begin
         num_errors++;
         $display("Error at %0t: got %h expected %h", $time, readData, e);
      end
   endtask : rd
   task automatic ticks(input int n);
      repeat (n) begin
         @(posedge sys_clk) instrClockTick <= 1'b1;
         @(posedge sys_clk) instrClockTick <= 1'b0;
      end
   endtask : ticks
   task automatic final_report;
      $display("Errors %0d, checks %0d", num_errors, checks);
      if (num_errors == 0 && checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : final_report
   initial begin
      #500000 num_errors++;
      final_report();
   end
   initial begin
      repeat (10) @(posedge sys_clk);
      rst <= 1'b0;
      powerOnReset <= 1'b0;
      rd(`ADDR_CONTROL, 8'h00);
      wr(`ADDR_CONTROL, 8'hff);
      rd(`ADDR_CONTROL, 8'h3f);
      wr(`ADDR_CONTROL, 8'h30);
      wr(`ADDR_COUNT_LO, 8'h34);
      wr(`ADDR_COUNT_HI, 8'h12);
      @(posedge sys_clk) rst <= 1'b1;
      @(posedge sys_clk) rst <= 1'b0;
      rd(`ADDR_CONTROL, 8'h30);
      // High, low, high again: equal high bytes mean a coherent pair
      rd(`ADDR_COUNT_HI, 8'h12);
      rd(`ADDR_COUNT_LO, 8'h34);
      rd(`ADDR_COUNT_HI, 8'h12);
      wr(5'h01, 8'h55);
      rd(5'h01, 8'h00);
      // Odd tick count leaves prescaler residue that the count write must clear
      for (int ps = 0; ps < 4; ps++) begin
         wr(`ADDR_COUNT_LO, 8'h00);
         wr(`ADDR_CONTROL, byte_t'(ps << 4) | 8'h01);
         ticks(7);
         wr(`ADDR_CONTROL, 8'h00);
         ticks(1);
         rd(`ADDR_COUNT_LO, byte_t'(7 >> ps));
      end
      wr(`ADDR_COUNT_LO, 8'hff);
      wr(`ADDR_COUNT_HI, 8'hff);
      wr(`ADDR_CONTROL, 8'h01);
      ticks(1);
      rd(`ADDR_FLAGS, 8'h01);
      rd(`ADDR_COUNT_HI, 8'h00);
      wr(`ADDR_FLAGS, 8'h00);
      rd(`ADDR_FLAGS, 8'h00);
      wr(`ADDR_COMPARE_LO, 8'h03);
      wr(`ADDR_COMPARE_HI, 8'h00);
      wr(`ADDR_COMPARE_CTL, 8'h0b);
      ticks(3);
      rd(`ADDR_COUNT_LO, 8'h00);
      rd(`ADDR_FLAGS, 8'h00);
      ticks(4);
      rd(`ADDR_COUNT_LO, 8'h01);
      // Unsynchronised mode: a match must not clear the count
      wr(`ADDR_CONTROL, 8'h06);
      wr(`ADDR_COUNT_LO, 8'h03);
      repeat (3) @(posedge sys_clk);
      rd(`ADDR_COUNT_LO, 8'h03);
      // A count write in the trigger cycle wins over the clear
      wr(`ADDR_COMPARE_LO, 8'h07);
      wr(`ADDR_COUNT_HI, 8'h01);
      wr(`ADDR_CONTROL, 8'h00);
      wr(`ADDR_COUNT_LO, 8'h07);
      wr2(`ADDR_COUNT_HI, 8'h00, `ADDR_COUNT_LO, 8'h22);
      rd(`ADDR_COUNT_LO, 8'h22);
      check_value(16'(matchCount), 16'h0003);
      wr(`ADDR_COMPARE_CTL, 8'h00);
      // External synced, external bypassed, crystal
      for (int m = 0; m < 3; m++) begin
         wr(`ADDR_CONTROL, 8'h00);
         wr(`ADDR_COUNT_LO, 8'h00);
         wr(`ADDR_CONTROL, 8'h03 | byte_t'(m << 2));
         repeat (4) @(posedge sys_clk);
         run <= 1'b1;
         repeat (38) @(posedge sys_clk);
         run <= 1'b0;
         repeat (10) @(posedge sys_clk);
         rd(`ADDR_COUNT_LO, 8'h05);
      end
      check_value({15'h0000, crystalOutputPin}, 16'h0001);
      @(posedge sys_clk) powerOnReset <= 1'b1;
      @(posedge sys_clk) powerOnReset <= 1'b0;
      rd(`ADDR_CONTROL, 8'h00);
      check_value({15'h0000, crystalOutputPin}, 16'h0000);
      final_report();
   end
endmodule : tb_top
